// [hw/nrcf_consts.vh]
/*
 * Constants for the contactless rate and framing configuration block:
 * register indices, byte addresses, field positions, reset values and
 * frame timing figures.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef NRCF_CONSTS_VH
`define NRCF_CONSTS_VH

// Register indices as printed, byte address is four times the index
`define NRCF_IDX_BIT_RATE 4'h4
`define NRCF_IDX_TYPE_A 4'h5
`define NRCF_IDX_TYPE_B 4'h6
`define NRCF_IDX_STATUS 4'h8
`define NRCF_ADDR_BIT_RATE 8'h10
`define NRCF_ADDR_TYPE_A 8'h14
`define NRCF_ADDR_TYPE_B 8'h18
`define NRCF_ADDR_STATUS 8'h20

// Reset values
`define NRCF_RST_BIT_RATE 8'h00
`define NRCF_RST_TYPE_A 8'h00
`define NRCF_RST_TYPE_B 8'h00

// Writable bit masks, reserved bits read zero
`define NRCF_MASK_BIT_RATE 8'h33
`define NRCF_MASK_TYPE_A 8'hFF
`define NRCF_MASK_TYPE_B 8'hFF

// Bit rate register fields
`define NRCF_TX_RATE_HI 5
`define NRCF_TX_RATE_LO 4
`define NRCF_RX_RATE_HI 1
`define NRCF_RX_RATE_LO 0

// Type A register fields
`define NRCF_A_NO_TX_PAR 7
`define NRCF_A_RAW_RX 6
`define NRCF_A_WRAP 5
`define NRCF_A_PLEN_HI 4
`define NRCF_A_PLEN_LO 1
`define NRCF_A_ANTICOLL 0

// Type B register fields
`define NRCF_B_EGT_HI 7
`define NRCF_B_EGT_LO 5
`define NRCF_B_SOF_LOW 4
`define NRCF_B_SOF_HIGH 3
`define NRCF_B_EOF_LOW 2
`define NRCF_B_MIDPOINT 1
`define NRCF_B_STREAM 0

// Rate codes and carrier divisors
`define NRCF_RATE_106 2'h0
`define NRCF_DIV_106 8'h80

// Transport frame start byte
`define NRCF_START_BYTE 8'hF0

// Type B durations in half etu, guard time limit in etu
`define NRCF_SOF_LOW_SHORT 5'h14
`define NRCF_SOF_LOW_LONG 5'h16
`define NRCF_SOF_LOW_MID 5'h15
`define NRCF_SOF_HIGH_SHORT 5'h04
`define NRCF_SOF_HIGH_LONG 5'h06
`define NRCF_SOF_HIGH_MID 5'h05
`define NRCF_EOF_LOW_SHORT 5'h14
`define NRCF_EOF_LOW_LONG 5'h16
`define NRCF_EOF_LOW_MID 5'h15
`define NRCF_EGT_MAX 3'h6

// Pulse width bases per rate, in carrier periods, for code 0000
`define NRCF_PW_BASE_128 6'h23
`define NRCF_PW_BASE_64 6'h12
`define NRCF_PW_BASE_32 6'h09
`define NRCF_PW_BASE_16 6'h05

`endif

// [hw/nrcf_bit_tick.v]
/*
 * Bit clock enable: divides carrier ticks by 128, 64, 32 or 16.
 * Assumes carrierTick is a one-cycle pulse on mclk per carrier period.
 */
`timescale 1ns/1ps
module nrcf_bit_tick (
  input wire mclk, // System clock
  input wire nrst, // Sync reset, active low
  input wire enable, // Counting allowed
  input wire carrierTick, // One pulse per carrier period
  input wire [1:0] rateCode, // Rate code, 0 slowest
  output reg bitTick // One pulse per bit period
);
`include "nrcf_consts.vh"

  reg [7:0] count_r;
  wire [7:0] divisor;

  // Divisor halves for each step of the code
  assign divisor = `NRCF_DIV_106 >> rateCode;

  // Count carrier periods up to one bit
  always @(posedge mclk) begin
    if (!nrst || !enable) begin
      count_r <= 8'h00;
      bitTick <= 1'b0;
    end else begin
      bitTick <= 1'b0;
      if (carrierTick) begin
        if (count_r >= divisor - 8'h01) begin
          count_r <= 8'h00;
          bitTick <= 1'b1;
        end else begin
          count_r <= count_r + 8'h01;
        end
      end
    end
  end

endmodule // nrcf_bit_tick

// [hw/nrcf_rate_frame_cfg.v]
/*
 * Rate and framing configuration for the contactless link: three
 * configuration registers plus a status word on an APB slave, decoded
 * into registered settings for the transmit and receive framers, and
 * bit rate enables derived from the carrier.
 * Assumes the carrier arrives as an asynchronous pin; mode inputs come
 * from logic on mclk.
 */
`timescale 1ns/1ps
module nrcf_rate_frame_cfg #(
  parameter [1:0] RATE_MAX = 2'h3 // Highest rate code the link supports
) (
  input wire mclk, // System clock 100 MHz
  input wire nrst, // Sync reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error
  input wire carrierPin, // Carrier clock from RF front end
  input wire readerMode, // High in reader modes, low in card emulation
  input wire coherentRx, // Coherent reception selected
  input wire oscOk, // Crystal clock stable
  output reg txRxEnable, // Transmit and receive allowed
  output reg [1:0] txRate, // Transmit rate code
  output reg [1:0] rxRate, // Receive rate code
  output reg txBitTick, // Transmit bit period pulse
  output reg rxBitTick, // Receive bit period pulse
  output reg txParityOff, // Send without parity bits
  output reg rawRxCapture, // Store raw stream with parity
  output reg rxChecksOff, // Skip parity and CRC checks
  output reg transportFrameWrap, // Add start and length bytes
  output reg [7:0] startByte, // Start byte to add and strip
  output reg [5:0] pulseWidth, // Modulation pulse in carrier periods
  output reg pulseValid, // Pulse code defined at this rate
  output reg antiCollFrame, // Bit oriented anticollision frames
  output reg [2:0] guardEtu, // Extra guard time in etu
  output reg [4:0] sofLowHalf, // Start low part, half etu
  output reg [4:0] sofHighHalf, // Start high part, half etu
  output reg [4:0] eofLowHalf, // End low part, half etu
  output reg eofNone, // No end of frame expected
  output reg lastByteKeep // Keep last full byte, no CRC
);
`include "nrcf_consts.vh"

  reg [7:0] bitRate_r;
  reg [7:0] typeA_r;
  reg [7:0] typeB_r;
  reg carrierMeta_r;
  reg carrierSync_r;
  reg carrierLast_r;
  reg carrierTick_r;
  wire txTick;
  wire rxTick;
  wire [1:0] txCode;
  wire [1:0] rxCode;
  wire [3:0] plen;
  wire [6:0] pulseDec;
  wire [2:0] egt;
  wire midpoint;
  wire stream;
  wire ratesOk;
  wire rawOk;
  wire apbAccess;
  wire addrHit;
  wire [7:0] wrByte;

  // Decode of pulse code: {valid, width}
  function [6:0] pulse_decode;
    input [1:0] rate;
    input [3:0] code;
    reg [5:0] base;
    reg signed [4:0] lo;
    reg signed [4:0] hi;
    reg signed [4:0] sc;
    begin
      base = `NRCF_PW_BASE_128;
      lo = -5'sd8;
      hi = 5'sd7;
      sc = {code[3], code};
      case (rate)
        2'h0: begin
          base = `NRCF_PW_BASE_128;
          lo = -5'sd8;
          hi = 5'sd7;
        end
        2'h1: begin
          base = `NRCF_PW_BASE_64;
          lo = -5'sd6;
          hi = 5'sd6;
        end
        2'h2: begin
          base = `NRCF_PW_BASE_32;
          lo = -5'sd4;
          hi = 5'sd4;
        end
        default: begin
          base = `NRCF_PW_BASE_16;
          lo = -5'sd3;
          hi = 5'sd3;
        end
      endcase
      if (sc >= lo && sc <= hi) begin
        pulse_decode = {1'b1, base + {{2{code[3]}}, code}};
      end else begin
        pulse_decode = 7'h00;
      end
    end
  endfunction

  // Rate code within what the link supports
  function rate_ok;
    input [1:0] code;
    begin
      rate_ok = (code <= RATE_MAX);
    end
  endfunction

  // Address decode
  function addr_mapped;
    input [7:0] addr;
    begin
      addr_mapped = (addr == `NRCF_ADDR_BIT_RATE) || (addr == `NRCF_ADDR_TYPE_A) ||
                    (addr == `NRCF_ADDR_TYPE_B) || (addr == `NRCF_ADDR_STATUS);
    end
  endfunction

  assign txCode = bitRate_r[`NRCF_TX_RATE_HI:`NRCF_TX_RATE_LO];
  assign rxCode = bitRate_r[`NRCF_RX_RATE_HI:`NRCF_RX_RATE_LO];
  assign ratesOk = rate_ok(txCode) && rate_ok(rxCode);
  assign plen = typeA_r[`NRCF_A_PLEN_HI:`NRCF_A_PLEN_LO];
  assign pulseDec = pulse_decode(txCode, plen);
  assign egt = typeB_r[`NRCF_B_EGT_HI:`NRCF_B_EGT_LO];
  assign midpoint = typeB_r[`NRCF_B_MIDPOINT];
  assign stream = typeB_r[`NRCF_B_STREAM] && coherentRx;
  // raw capture only reader mode at 106
  assign rawOk = typeA_r[`NRCF_A_RAW_RX] && readerMode && (rxCode == `NRCF_RATE_106);
  assign apbAccess = psel && penable;
  assign addrHit = addr_mapped(paddr);
  assign wrByte = pwdata[7:0];

  // Carrier pin synchroniser and edge pulse
  always @(posedge mclk) begin
    if (!nrst) begin
      carrierMeta_r <= 1'b0;
      carrierSync_r <= 1'b0;
      carrierLast_r <= 1'b0;
      carrierTick_r <= 1'b0;
    end else begin
      carrierMeta_r <= carrierPin;
      carrierSync_r <= carrierMeta_r;
      carrierLast_r <= carrierSync_r;
      carrierTick_r <= carrierSync_r && !carrierLast_r;
    end
  end

  nrcf_bit_tick uTxTick (
    .mclk(mclk),
    .nrst(nrst),
    .enable(ratesOk),
    .carrierTick(carrierTick_r),
    .rateCode(txCode),
    .bitTick(txTick)
  );

  nrcf_bit_tick uRxTick (
    .mclk(mclk),
    .nrst(nrst),
    .enable(ratesOk),
    .carrierTick(carrierTick_r),
    .rateCode(rxCode),
    .bitTick(rxTick)
  );

  // APB slave, one wait state, write lands at the ready edge
  always @(posedge mclk) begin
    if (!nrst) begin
      bitRate_r <= `NRCF_RST_BIT_RATE;
      typeA_r <= `NRCF_RST_TYPE_A;
      typeB_r <= `NRCF_RST_TYPE_B;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (apbAccess && !pready) begin
        pready <= 1'b1;
        // Unmapped, or a write without a stable oscillator, is refused
        pslverr <= !addrHit || (pwrite && !oscOk);
        prdata <= 32'h0000_0000;
        if (!pwrite) begin
          case (paddr)
            `NRCF_ADDR_BIT_RATE: begin
              prdata <= {24'h00_0000, bitRate_r};
            end
            `NRCF_ADDR_TYPE_A: begin
              prdata <= {24'h00_0000, typeA_r};
            end
            `NRCF_ADDR_TYPE_B: begin
              prdata <= {24'h00_0000, typeB_r};
            end
            `NRCF_ADDR_STATUS: begin
              prdata <= {24'h00_0000, txRxEnable, pulseValid, pulseWidth};
            end
            default: begin
              prdata <= 32'h0000_0000;
            end
          endcase
        end
      end
      // writes taken only with stable oscillator
      if (apbAccess && pready && pwrite && oscOk) begin
        case (paddr)
          `NRCF_ADDR_BIT_RATE: begin
            bitRate_r <= wrByte & `NRCF_MASK_BIT_RATE;
          end
          `NRCF_ADDR_TYPE_A: begin
            typeA_r <= wrByte & `NRCF_MASK_TYPE_A;
          end
          `NRCF_ADDR_TYPE_B: begin
            typeB_r <= wrByte & `NRCF_MASK_TYPE_B;
          end
          default: begin
            bitRate_r <= bitRate_r;
          end
        endcase
      end
    end
  end

  // Registered rate and type A settings
  always @(posedge mclk) begin
    if (!nrst) begin
      txRxEnable <= 1'b0;
      txRate <= 2'h0;
      rxRate <= 2'h0;
      txBitTick <= 1'b0;
      rxBitTick <= 1'b0;
      txParityOff <= 1'b0;
      rawRxCapture <= 1'b0;
      rxChecksOff <= 1'b0;
      transportFrameWrap <= 1'b0;
      startByte <= 8'h00;
      pulseWidth <= 6'h00;
      pulseValid <= 1'b0;
      antiCollFrame <= 1'b0;
    end else begin
      txRxEnable <= ratesOk;
      txRate <= txCode;
      rxRate <= rxCode;
      txBitTick <= txTick;
      rxBitTick <= rxTick;
      txParityOff <= typeA_r[`NRCF_A_NO_TX_PAR] && readerMode;
      rawRxCapture <= rawOk;
      rxChecksOff <= rawOk || stream;
      // transport frame wrap with start byte
      transportFrameWrap <= typeA_r[`NRCF_A_WRAP];
      startByte <= typeA_r[`NRCF_A_WRAP] ? `NRCF_START_BYTE : 8'h00;
      pulseWidth <= pulseDec[5:0];
      pulseValid <= pulseDec[6];
      antiCollFrame <= typeA_r[`NRCF_A_ANTICOLL];
    end
  end

  // Registered type B timing
  always @(posedge mclk) begin
    if (!nrst) begin
      guardEtu <= 3'h0;
      sofLowHalf <= `NRCF_SOF_LOW_SHORT;
      sofHighHalf <= `NRCF_SOF_HIGH_SHORT;
      eofLowHalf <= `NRCF_EOF_LOW_SHORT;
      eofNone <= 1'b0;
      lastByteKeep <= 1'b0;
    end else begin
      guardEtu <= (egt > `NRCF_EGT_MAX) ? `NRCF_EGT_MAX : egt;
      eofNone <= stream;
      lastByteKeep <= stream;
      if (stream) begin
        sofLowHalf <= `NRCF_SOF_LOW_SHORT;
        sofHighHalf <= `NRCF_SOF_HIGH_SHORT;
        eofLowHalf <= `NRCF_EOF_LOW_SHORT;
      end else if (midpoint) begin
        sofLowHalf <= `NRCF_SOF_LOW_MID;
        sofHighHalf <= `NRCF_SOF_HIGH_MID;
        eofLowHalf <= `NRCF_EOF_LOW_MID;
      end else begin
        sofLowHalf <= typeB_r[`NRCF_B_SOF_LOW] ? `NRCF_SOF_LOW_LONG : `NRCF_SOF_LOW_SHORT;
        sofHighHalf <= typeB_r[`NRCF_B_SOF_HIGH] ? `NRCF_SOF_HIGH_LONG : `NRCF_SOF_HIGH_SHORT;
        eofLowHalf <= typeB_r[`NRCF_B_EOF_LOW] ? `NRCF_EOF_LOW_LONG : `NRCF_EOF_LOW_SHORT;
      end
    end
  end

endmodule // nrcf_rate_frame_cfg

// [dv/nrcf_carrier_model.sv]
/* Carrier source standing in for the RF front end.
   Assumes an 80 ns scaled carrier, eight mclk periods. */
`timescale 1ns/1ps
module nrcf_carrier_model #(
  parameter int HALF = 40 // Half period in ns
) (
  output logic carrierPin // Carrier to the block
);
  // Free running carrier, its edges always fall on mclk falling edges
  initial carrierPin = 1'h0;
  always #(HALF) carrierPin = ~carrierPin;
endmodule // nrcf_carrier_model

// [dv/nrcf_rate_frame_cfg_sva.sv]
/* Checker for the rate and framing block.
   Assumes binding to the block top; one mclk domain. */
`timescale 1ns/1ps
module nrcf_rate_frame_cfg_sva #(
  parameter [1:0] RATE_MAX = 2'h3 // Highest rate code
) (
  input wire mclk, // Clock
  input wire nrst, // Reset
  input wire pwrite, // Direction
  input wire pready, // Ready
  input wire pslverr, // Error
  input wire oscOk, // Oscillator good
  input wire readerMode, // Reader mode
  input wire txRxEnable, // Link on
  input wire [1:0] txRate, // Tx code
  input wire [1:0] rxRate, // Rx code
  input wire txParityOff, // No parity
  input wire rawRxCapture, // Raw capture
  input wire rxChecksOff, // No checks
  input wire transportFrameWrap, // Wrap on
  input wire [7:0] startByte, // Start byte
  input wire [5:0] pulseWidth, // Pulse width
  input wire pulseValid, // Pulse ok
  input wire [2:0] guardEtu, // Guard
  input wire [4:0] sofLowHalf, // Sof low
  input wire [4:0] sofHighHalf, // Sof high
  input wire [4:0] eofLowHalf, // Eof low
  input wire eofNone, // No eof
  input wire lastByteKeep // Keep byte
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Link and frame option relations
  property p_en;
    $past(nrst) |-> txRxEnable == (txRate <= RATE_MAX && rxRate <= RATE_MAX);
  endproperty
  a_en: assert property (p_en) else $error("link enable wrong");
  property p_par;
    txParityOff |-> $past(readerMode);
  endproperty
  a_par: assert property (p_par) else $error("parity off in card mode");
  property p_raw;
    rawRxCapture |-> rxRate == 2'h0 && rxChecksOff;
  endproperty
  a_raw: assert property (p_raw) else $error("raw capture wrong");
  property p_sb;
    startByte == (transportFrameWrap ? 8'hF0 : 8'h00);
  endproperty
  a_sb: assert property (p_sb) else $error("start byte wrong");
  property p_pw;
    pulseValid && txRate == 2'h0 |-> pulseWidth >= 6'h1B && pulseWidth <= 6'h2A;
  endproperty
  a_pw: assert property (p_pw) else $error("pulse width out of range");
  property p_egt;
    guardEtu <= 3'h6;
  endproperty
  a_egt: assert property (p_egt) else $error("guard too long");
  property p_mid;
    sofHighHalf == 5'h05 |-> sofLowHalf == 5'h15 && eofLowHalf == 5'h15;
  endproperty
  a_mid: assert property (p_mid) else $error("midpoint timing wrong");
  property p_str;
    eofNone |-> sofLowHalf == 5'h14 && sofHighHalf == 5'h04 && lastByteKeep;
  endproperty
  a_str: assert property (p_str) else $error("stream timing wrong");
  property p_osc;
    pready && pwrite && !$past(oscOk) |-> pslverr;
  endproperty
  a_osc: assert property (p_osc) else $error("write taken without clock");
endmodule // nrcf_rate_frame_cfg_sva

bind nrcf_rate_frame_cfg nrcf_rate_frame_cfg_sva #(.RATE_MAX(RATE_MAX)) chk (
  .mclk(mclk), .nrst(nrst), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .oscOk(oscOk), .readerMode(readerMode), .txRxEnable(txRxEnable), .txRate(txRate),
  .rxRate(rxRate), .txParityOff(txParityOff), .rawRxCapture(rawRxCapture),
  .rxChecksOff(rxChecksOff), .transportFrameWrap(transportFrameWrap), .startByte(startByte),
  .pulseWidth(pulseWidth), .pulseValid(pulseValid), .guardEtu(guardEtu),
  .sofLowHalf(sofLowHalf), .sofHighHalf(sofHighHalf), .eofLowHalf(eofLowHalf),
  .eofNone(eofNone), .lastByteKeep(lastByteKeep)
);

// [dv/tb_nrcf_rate_frame_cfg.sv]
/* Register level testbench for the rate and framing block.
   Assumes the carrier model and the bound checker. */
`timescale 1ns/1ps
module tb_nrcf_rate_frame_cfg;
  logic mclk = 1'h0;
  logic nrst = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, rerr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat, e;
  logic readerMode = 1'h1, coherentRx = 1'h0, oscOk = 1'h1, carrierPin;
  logic pready, pslverr, txRxEnable, txBitTick, rxBitTick, txParityOff, rawRxCapture;
  logic rxChecksOff, transportFrameWrap, pulseValid, antiCollFrame, eofNone, lastByteKeep;
  logic [1:0] txRate, rxRate;
  logic [7:0] startByte;
  logic [5:0] pulseWidth;
  logic [2:0] guardEtu;
  logic [4:0] sofLowHalf, sofHighHalf, eofLowHalf;
  logic [12:0] aOut;
  logic [19:0] bOut;
  int err_total = 0, n_checks = 0, s, ok;
  int base[4] = '{35, 18, 9, 5};
  int lim[4] = '{8, 6, 4, 3};

  // Clock and grouped outputs
  always #5 mclk = ~mclk;
  assign aOut = {txParityOff, rawRxCapture, rxChecksOff, transportFrameWrap, antiCollFrame,
                 startByte};
  assign bOut = {guardEtu, sofLowHalf, sofHighHalf, eofLowHalf, eofNone, lastByteKeep};

  nrcf_rate_frame_cfg #(.RATE_MAX(2'h2)) dut (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .carrierPin(carrierPin), .readerMode(readerMode), .coherentRx(coherentRx), .oscOk(oscOk),
    .txRxEnable(txRxEnable), .txRate(txRate), .rxRate(rxRate), .txBitTick(txBitTick),
    .rxBitTick(rxBitTick), .txParityOff(txParityOff), .rawRxCapture(rawRxCapture),
    .rxChecksOff(rxChecksOff), .transportFrameWrap(transportFrameWrap), .startByte(startByte),
    .pulseWidth(pulseWidth), .pulseValid(pulseValid), .antiCollFrame(antiCollFrame),
    .guardEtu(guardEtu), .sofLowHalf(sofLowHalf), .sofHighHalf(sofHighHalf),
    .eofLowHalf(eofLowHalf), .eofNone(eofNone), .lastByteKeep(lastByteKeep)
  );
  nrcf_carrier_model cm (.carrierPin(carrierPin));

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, g, x);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20)
      err_total++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'h0, a, 8'h00);
    chk(rdat, x);
  endtask

  // Let decoded outputs land, sample mid cycle
  task automatic st;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask

  // Bit period in mclk cycles between two ticks
  task automatic tick(input bit rx, input int c);
    int k = 0;
    while ((rx ? rxBitTick : txBitTick) !== 1'h1 && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while ((rx ? rxBitTick : txBitTick) !== 1'h1 && k < 3000);
    chk(k, (128 >> c) * 8);
  endtask

  // Watchdog, tests need about a quarter of this
  initial begin
    #300us;
    err_total++;
    close_out;
  end

  initial begin
    repeat (16) @(posedge mclk);
    nrst <= 1'h1;
    st;
    rd(8'h10, 32'h0000_0000);
    rd(8'h18, 32'h0000_0000);
    rd(8'h20, 32'h0000_00E3);
    chk(bOut, {3'h0, 5'h14, 5'h04, 5'h14, 2'h0});
    apb(1'h1, 8'h10, 8'hFF);
    rd(8'h10, 32'h0000_0033);
    chk({txRate, rxRate, txRxEnable}, 5'h1E);
    apb(1'h1, 8'h10, 8'h03);
    st;
    chk({txRate, rxRate, txRxEnable}, 5'h06);
    for (int c = 0; c < 3; c++) begin
      apb(1'h1, 8'h10, {2'h0, c[1:0], 2'h0, 2'(2 - c)});
      st;
      chk({txRate, rxRate, txRxEnable}, {c[1:0], 2'(2 - c), 1'h1});
      tick(1'h0, c);
      tick(1'h1, 2 - c);
    end
    @(posedge mclk);
    oscOk <= 1'h0;
    apb(1'h1, 8'h10, 8'h11);
    chk(rerr, 1'h1);
    @(posedge mclk);
    oscOk <= 1'h1;
    rd(8'h10, 32'h0000_0020);
    rd(8'h30, 32'h0000_0000);
    chk(rerr, 1'h1);
    for (int r = 0; r < 4; r++) begin
      apb(1'h1, 8'h10, {2'h0, r[1:0], 4'h0});
      for (int c = 0; c < 16; c++) begin
        s = c < 8 ? c : c - 16;
        ok = s >= -lim[r] && s <= lim[r];
        apb(1'h1, 8'h14, {3'h0, c[3:0], 1'h0});
        st;
        chk({pulseValid, pulseWidth}, ok ? 32'h0000_0040 + base[r] + s : 0);
      end
    end
    apb(1'h1, 8'h10, 8'h00);
    // no rate detection mode here, wrap may be set
    apb(1'h1, 8'h14, 8'hE1);
    st;
    chk(aOut, {5'h1F, 8'hF0});
    apb(1'h1, 8'h14, 8'hE0);
    @(posedge mclk);
    readerMode <= 1'h0;
    st;
    chk(aOut, {5'h02, 8'hF0});
    @(posedge mclk);
    readerMode <= 1'h1;
    apb(1'h1, 8'h10, 8'h01);
    st;
    chk(aOut, {5'h12, 8'hF0});
    apb(1'h1, 8'h14, 8'h00);
    for (int g = 0; g < 8; g++) begin
      apb(1'h1, 8'h18, {g[2:0], g[0], g[1], g[2], 2'h0});
      st;
      e = {g > 6 ? 3'h6 : 3'(g), 5'h14 + 5'(2 * g[0]), 5'h04 + 5'(2 * g[1])};
      chk(bOut, {e[12:0], 5'h14 + 5'(2 * g[2]), 2'h0});
    end
    apb(1'h1, 8'h18, 8'h1F);
    st;
    chk(bOut, {3'h0, 5'h15, 5'h05, 5'h15, 2'h0});
    @(posedge mclk);
    coherentRx <= 1'h1;
    st;
    chk({bOut, rxChecksOff}, {3'h0, 5'h14, 5'h04, 5'h14, 3'h7});
    // Second reset in mid-run, registers back to defaults
    @(posedge mclk);
    nrst <= 1'h0;
    repeat (3) @(posedge mclk);
    nrst <= 1'h1;
    st;
    rd(8'h10, 32'h0000_0000);
    chk(bOut, {3'h0, 5'h14, 5'h04, 5'h14, 2'h0});
    chk(aOut, 13'h0000);
    close_out;
  end
endmodule // tb_nrcf_rate_frame_cfg
